// *** common/ppas_regs.vh ***
// register map, field positions and reset values of the parallel port block
`ifndef PPAS_REGS_VH
`define PPAS_REGS_VH

// word offsets on the register bus
`define PPAS_OFS_CTRL     8'h00
`define PPAS_OFS_ADDR     8'h04
`define PPAS_OFS_PINEN    8'h08
`define PPAS_OFS_STAT     8'h0C
`define PPAS_OFS_INBUF0   8'h10
`define PPAS_OFS_OUTBUF0  8'h20
`define PPAS_OFS_IRQSTAT  8'h30
`define PPAS_OFS_IRQMASK  8'h34

// control register fields
`define PPAS_CTRL_MODE_LO  8
`define PPAS_CTRL_INCREMENT_MODE_LO  11
`define PPAS_CTRL_INTERRUPT_REQUEST_MODE_LO  13
`define PPAS_CTRL_CSF_LO   6
`define PPAS_CTRL_AMUX_LO  3

// port mode codes
`define PPAS_MODE_LEGACY   2'b00
`define PPAS_MODE_ENH      2'b01
`define PPAS_MODE_MASTER2  2'b10
`define PPAS_MODE_MASTER1  2'b11

// chip select function, increment and interrupt mode codes
`define PPAS_CSF_CS1       2'b10
`define PPAS_INCREMENT_MODE_AUTO     2'b11
`define PPAS_INTERRUPT_REQUEST_MODE_CYCLE    2'b01
`define PPAS_INTERRUPT_REQUEST_MODE_BUF3     2'b10

// address and pin enable register fields
`define PPAS_LINE14_BIT    14
`define PPAS_ADDR_MASK     32'h0000_47FF

// status register fields
`define PPAS_ST_IBF        15
`define PPAS_ST_INPUT_OVERFLOW_FLAG       14
`define PPAS_ST_INPUT_BUFFER_N_FULL_LO    8
`define PPAS_ST_OBE        7
`define PPAS_ST_OUTPUT_UNDERFLOW_FLAG       6

// interrupt status bits
`define PPAS_IRQ_OVF       0
`define PPAS_IRQ_UNF       1
`define PPAS_IRQ_CYCLE     2
`define PPAS_IRQ_BUF3      3

// reset values
`define PPAS_RST_ZERO      32'h0000_0000
`define PPAS_RST_EMPTY     4'hF

`endif

// *** hw/ppas_pin_sync.v ***
// three-stage pin synchroniser, accepts a change when stages two and three agree
`timescale 1ns/1ps
module ppas_pin_sync #(
   parameter WIDTH = 13,
   parameter [WIDTH-1:0] INIT = {WIDTH{1'b1}}
) (
   input wire hclk,
   input wire hresetn,
   input wire [WIDTH-1:0] pin_in,
   output reg [WIDTH-1:0] pin_sync
);

reg [WIDTH-1:0] stage1;
reg [WIDTH-1:0] stage2;
reg [WIDTH-1:0] stage3;

// stage1 feeds stage2 only; the agreement test filters single-cycle glitches
always @(posedge hclk or negedge hresetn) begin
   if (!hresetn) begin
      stage1 <= INIT;
      stage2 <= INIT;
      stage3 <= INIT;
      pin_sync <= INIT;
   end else begin
      stage1 <= pin_in;
      stage2 <= stage1;
      stage3 <= stage2;
      pin_sync <= (stage2 & stage3) | (pin_sync & (stage2 ^ stage3));
   end
end

endmodule

// *** hw/ppas_port.v ***
// parallel port address, pad enable and slave buffer block on AHB-Lite
//
// What this block does
// - function 10 makes bit 14 chip select one
// - functions 00/01 make bit 14 address line
// - bits 10:0 hold the destination address
// - unused bits ignore writes, read zero
// - line 14 enable gives pad to port
// - enables 10:2 route pads to address lines
// - enables 1:0 give address bits only when amux is 00; latch strobes stay low
// - external strobes move buffer flags only in slave modes
// - all-full reads 1 when every input full
// - overflow set on write to full buffer
// - per-buffer full cleared by software read
// - all-empty reads 1 when outputs empty
// - underflow set on read of empty buffer
// - per-buffer empty cleared by software write
// - mode field selects slave or master variants
// - interrupt mode 10 fires on buffer 3
// - auto-increment pointers in legacy slave mode
`timescale 1ns/1ps
`include "ppas_regs.vh"
module ppas_port (
   input wire hclk,
   input wire hresetn,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg hreadyout,
   output reg hresp,
   output reg [31:0] hrdata,
   input wire ext_cs_n,
   input wire ext_rd_n,
   input wire ext_wr_n,
   input wire [1:0] ext_addr,
   input wire [7:0] ext_data_in,
   output reg [7:0] ext_data_out,
   output reg ext_data_oe,
   output reg [10:0] port_address_lines,
   output reg address_line_14,
   output reg chip_select_pin_one,
   output reg address_latch_high,
   output reg address_latch_low,
   output reg [14:0] pad_port_owned,
   output reg irq
);

// picks the buffer of an external access: pins in enhanced, pointer with auto-increment, else buffer 0
function [1:0] ppas_buf_sel;
   input [1:0] mode;
   input [1:0] increment_mode;
   input [1:0] ptr;
   input [1:0] pin_addr;
   begin
      if (mode == `PPAS_MODE_ENH)
         ppas_buf_sel = pin_addr;
      else if (increment_mode == `PPAS_INCREMENT_MODE_AUTO)
         ppas_buf_sel = ptr;
      else
         ppas_buf_sel = 2'b00;
   end
endfunction

// software-visible registers and buffers, plus the internal buffer pointers
reg [31:0] ctrl;
reg [31:0] addr_reg;
reg [31:0] pin_en;
reg [3:0] irq_stat;
reg [3:0] irq_mask;
reg input_overflow_flag;
reg output_underflow_flag;
reg [3:0] input_buffer_n_full;
reg [3:0] output_buffer_n_empty;
reg [7:0] in_buf [0:3];
reg [7:0] out_buf [0:3];
reg [1:0] wr_ptr;
reg [1:0] rd_ptr;

// bus phase tracking
reg wr_pend;
reg rd_pend;
reg [7:0] bus_addr;

// synchronised pins and their previous values
wire [12:0] pins_sync;
reg rd_prev_n;
reg wr_prev_n;

wire [1:0] mode = ctrl[`PPAS_CTRL_MODE_LO+1:`PPAS_CTRL_MODE_LO];
wire [1:0] increment_mode = ctrl[`PPAS_CTRL_INCREMENT_MODE_LO+1:`PPAS_CTRL_INCREMENT_MODE_LO];
wire [1:0] interrupt_request_mode = ctrl[`PPAS_CTRL_INTERRUPT_REQUEST_MODE_LO+1:`PPAS_CTRL_INTERRUPT_REQUEST_MODE_LO];
wire [1:0] chip_select_function = ctrl[`PPAS_CTRL_CSF_LO+1:`PPAS_CTRL_CSF_LO];
wire [1:0] amux = ctrl[`PPAS_CTRL_AMUX_LO+1:`PPAS_CTRL_AMUX_LO];

ppas_pin_sync #(
   .WIDTH(13),
   .INIT(13'h1_F00)
) u_pin_sync (
   .hclk(hclk),
   .hresetn(hresetn),
   .pin_in({ext_cs_n, ext_rd_n, ext_wr_n, ext_addr, ext_data_in}),
   .pin_sync(pins_sync)
);

wire cs_s_n = pins_sync[12];
wire rd_s_n = pins_sync[11];
wire wr_s_n = pins_sync[10];
wire [1:0] addr_s = pins_sync[9:8];
wire [7:0] data_s = pins_sync[7:0];

// slave modes only: master codes ignore the external strobes
wire slave_mode = (mode == `PPAS_MODE_LEGACY) || (mode == `PPAS_MODE_ENH);
wire ext_wr_evt = slave_mode & ~cs_s_n & wr_prev_n & ~wr_s_n;
wire ext_rd_evt = slave_mode & ~cs_s_n & rd_prev_n & ~rd_s_n;
wire [1:0] wsel = ppas_buf_sel(mode, increment_mode, wr_ptr, addr_s);
wire [1:0] rsel = ppas_buf_sel(mode, increment_mode, rd_ptr, addr_s);

// overflow: write to an already full input buffer
wire ovf_evt = ext_wr_evt & input_buffer_n_full[wsel];
// underflow: read of an empty output buffer
wire unf_evt = ext_rd_evt & output_buffer_n_empty[rsel];

// buffer 3 access, or pins at 11 in enhanced mode
wire buf3_evt = (interrupt_request_mode == `PPAS_INTERRUPT_REQUEST_MODE_BUF3) &&
   (((mode == `PPAS_MODE_LEGACY) &&
     ((ext_wr_evt && wsel == 2'b11) || (ext_rd_evt && rsel == 2'b11))) ||
    ((mode == `PPAS_MODE_ENH) && (ext_wr_evt || ext_rd_evt) &&
     addr_s == 2'b11));
wire cycle_evt = (interrupt_request_mode == `PPAS_INTERRUPT_REQUEST_MODE_CYCLE) && (ext_wr_evt || ext_rd_evt);

// bus request decode
wire bus_req = hsel & hready & htrans[1];
wire rd_buf_hit = rd_pend && bus_addr[7:4] == 4'h1;
wire wr_buf_hit = wr_pend && bus_addr[7:4] == 4'h2;
wire [1:0] bus_idx = bus_addr[3:2];

// status word assembled from the live flags
wire [31:0] stat_word = {16'h0000,
   &input_buffer_n_full, input_overflow_flag, 2'b00, input_buffer_n_full,
   &output_buffer_n_empty, output_underflow_flag, 2'b00,
   output_buffer_n_empty};

// read mux; unimplemented bits come back as zero
reg [31:0] read_mux;
always @* begin
   read_mux = `PPAS_RST_ZERO;
   case (bus_addr)
      `PPAS_OFS_CTRL: read_mux = ctrl;
      `PPAS_OFS_ADDR: read_mux = addr_reg;
      `PPAS_OFS_PINEN: read_mux = pin_en;
      `PPAS_OFS_STAT: read_mux = stat_word;
      `PPAS_OFS_IRQSTAT: read_mux = {28'h000_0000, irq_stat};
      `PPAS_OFS_IRQMASK: read_mux = {28'h000_0000, irq_mask};
      default: begin
         if (bus_addr[7:4] == 4'h1)
            read_mux = {24'h00_0000, in_buf[bus_idx]};
         else if (bus_addr[7:4] == 4'h2)
            read_mux = {24'h00_0000, out_buf[bus_idx]};
         else
            read_mux = `PPAS_RST_ZERO;
      end
   endcase
end

// bus handshake: writes take no wait, reads take one wait state
always @(posedge hclk or negedge hresetn) begin
   if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= `PPAS_RST_ZERO;
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      bus_addr <= 8'h00;
   end else begin
      hresp <= 1'b0;
      if (rd_pend) begin
         hrdata <= read_mux;
         hreadyout <= 1'b1;
         rd_pend <= 1'b0;
         wr_pend <= 1'b0;
      end else if (bus_req) begin
         bus_addr <= {haddr[7:2], 2'b00};
         wr_pend <= hwrite;
         rd_pend <= ~hwrite;
         hreadyout <= hwrite;
      end else if (hready) begin
         wr_pend <= 1'b0;
      end
   end
end

// control, address and pin enable registers
always @(posedge hclk or negedge hresetn) begin
   if (!hresetn) begin
      ctrl <= `PPAS_RST_ZERO;
      addr_reg <= `PPAS_RST_ZERO;
      pin_en <= `PPAS_RST_ZERO;
      irq_mask <= 4'h0;
   end else if (wr_pend) begin
      case (bus_addr)
         `PPAS_OFS_CTRL: ctrl <= hwdata & 32'h0000_7BD8;
         // destination address; drops bits 31:15, 13:11
         `PPAS_OFS_ADDR: addr_reg <= hwdata & `PPAS_ADDR_MASK;
         // same mask on the pad enables
         `PPAS_OFS_PINEN: pin_en <= hwdata & `PPAS_ADDR_MASK;
         `PPAS_OFS_IRQMASK: irq_mask <= hwdata[3:0];
         default: irq_mask <= irq_mask;
      endcase
   end
end

// buffer storage: external writes fill inputs, software fills outputs
always @(posedge hclk) begin
   if (ext_wr_evt && !input_buffer_n_full[wsel])
      in_buf[wsel] <= data_s;
   if (wr_buf_hit)
      out_buf[bus_idx] <= hwdata[7:0];
end

// per-buffer flags; hardware set has the last word
always @(posedge hclk or negedge hresetn) begin
   if (!hresetn) begin
      input_buffer_n_full <= 4'h0;
      // every output buffer counts as empty after reset
      output_buffer_n_empty <= `PPAS_RST_EMPTY;
   end else begin
      // a software read of an input buffer clears its full flag
      if (rd_buf_hit)
         input_buffer_n_full[bus_idx] <= 1'b0;
      // a software write marks the output buffer loaded
      if (wr_buf_hit)
         output_buffer_n_empty[bus_idx] <= 1'b0;
      // set beats clear on the same buffer
      if (ext_wr_evt)
         input_buffer_n_full[wsel] <= 1'b1;
      // empty again only once the byte has been transmitted
      if (ext_rd_evt)
         output_buffer_n_empty[rsel] <= 1'b1;
   end
end

// sticky error flags, cleared by writing zero to the status register
always @(posedge hclk or negedge hresetn) begin
   if (!hresetn) begin
      input_overflow_flag <= 1'b0;
      output_underflow_flag <= 1'b0;
   end else begin
      // hardware set wins over a clearing write
      if (ovf_evt)
         input_overflow_flag <= 1'b1;
      else if (wr_pend && bus_addr == `PPAS_OFS_STAT && !hwdata[`PPAS_ST_INPUT_OVERFLOW_FLAG])
         input_overflow_flag <= 1'b0;
      if (unf_evt)
         output_underflow_flag <= 1'b1;
      else if (wr_pend && bus_addr == `PPAS_OFS_STAT && !hwdata[`PPAS_ST_OUTPUT_UNDERFLOW_FLAG])
         output_underflow_flag <= 1'b0;
   end
end

// legacy auto-increment walks the write pointer after each write, the read pointer after each read
always @(posedge hclk or negedge hresetn) begin
   if (!hresetn) begin
      wr_ptr <= 2'b00;
      rd_ptr <= 2'b00;
   end else if (mode == `PPAS_MODE_LEGACY && increment_mode == `PPAS_INCREMENT_MODE_AUTO) begin
      if (ext_wr_evt)
         wr_ptr <= wr_ptr + 2'b01;
      if (ext_rd_evt)
         rd_ptr <= rd_ptr + 2'b01;
   end else begin
      wr_ptr <= 2'b00;
      rd_ptr <= 2'b00;
   end
end

// external data bus: drive while the host strobes a read
always @(posedge hclk or negedge hresetn) begin
   if (!hresetn) begin
      rd_prev_n <= 1'b1;
      wr_prev_n <= 1'b1;
      ext_data_out <= 8'h00;
      ext_data_oe <= 1'b0;
   end else begin
      rd_prev_n <= rd_s_n;
      wr_prev_n <= wr_s_n;
      if (ext_rd_evt) begin
         // an empty buffer yields zero rather than stale data
         ext_data_out <= output_buffer_n_empty[rsel] ? 8'h00 : out_buf[rsel];
         ext_data_oe <= 1'b1;
      end else if (rd_s_n || cs_s_n) begin
         ext_data_oe <= 1'b0;
      end
   end
end

// interrupt status: sticky, cleared by reading, new events win
always @(posedge hclk or negedge hresetn) begin
   if (!hresetn) begin
      irq_stat <= 4'h0;
      irq <= 1'b0;
   end else begin
      irq_stat <= (irq_stat &
         ~((rd_pend && bus_addr == `PPAS_OFS_IRQSTAT) ? 4'hF : 4'h0)) |
         {buf3_evt, cycle_evt, unf_evt, ovf_evt};
      irq <= |(irq_stat & irq_mask);
   end
end

// pad ownership and address pins, all registered
always @(posedge hclk or negedge hresetn) begin
   if (!hresetn) begin
      port_address_lines <= 11'h000;
      address_line_14 <= 1'b0;
      chip_select_pin_one <= 1'b0;
      address_latch_high <= 1'b0;
      address_latch_low <= 1'b0;
      pad_port_owned <= 15'h0000;
   end else begin
      // set enables hand pads to the port
      pad_port_owned <= pin_en[14:0];
      // lines 10:2 carry the address when enabled
      port_address_lines[10:2] <= addr_reg[10:2] & pin_en[10:2];
      // without multiplexing the low pads carry address bits
      port_address_lines[1:0] <= (amux == 2'b00) ?
         (addr_reg[1:0] & pin_en[1:0]) : 2'b00;
      // latch strobes are held low in every mode; nothing pulses them
      address_latch_high <= 1'b0;
      address_latch_low <= 1'b0;
      // function 10: bit 14 is chip select one
      chip_select_pin_one <= pin_en[`PPAS_LINE14_BIT] &&
         chip_select_function == `PPAS_CSF_CS1 && addr_reg[`PPAS_LINE14_BIT];
      // functions 00 and 01: bit 14 is an address line
      address_line_14 <= pin_en[`PPAS_LINE14_BIT] && !chip_select_function[1] &&
         addr_reg[`PPAS_LINE14_BIT];
   end
end

endmodule

// *** sim/ppas_port_props.sv ***
// port-level assertions for the parallel port block
`timescale 1ns/1ps
module ppas_port_props (
   input wire hclk,
   input wire hresetn,
   input wire hsel,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire hready,
   input wire hreadyout,
   input wire hresp,
   input wire ext_cs_n,
   input wire ext_rd_n,
   input wire ext_data_oe,
   input wire [10:0] port_address_lines,
   input wire address_line_14,
   input wire chip_select_pin_one,
   input wire address_latch_high,
   input wire address_latch_low,
   input wire [14:0] pad_port_owned,
   input wire irq
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   wire take;
   // a request is taken only while the bus is ready
   assign take = hsel && hready && htrans[1];
   a_write_no_wait: assert property (take && hwrite |=> hreadyout)
      else $error("write stalled");
   a_read_one_wait: assert property (take && !hwrite |=>
      !hreadyout ##1 hreadyout) else $error("read wait wrong");
   a_resp_okay: assert property (hresp == 1'b0)
      else $error("error response");
   // one-cycle slack, the pad copy may lead the gated outputs
   a_line14_owned: assert property ((address_line_14 || chip_select_pin_one)
      |-> pad_port_owned[14] || $past(pad_port_owned[14]))
      else $error("line 14 driven on released pad");
   a_addr_gated: assert property ((port_address_lines[10:2] &
      ~(pad_port_owned[10:2] | $past(pad_port_owned[10:2]))) == 9'h0)
      else $error("address on released pad");
   a_low_gated: assert property ((port_address_lines[1:0] &
      ~(pad_port_owned[1:0] | $past(pad_port_owned[1:0]))) == 2'h0)
      else $error("low address on released pad");
   a_cs_exclusive: assert property (!(address_line_14
      && chip_select_pin_one)) else $error("line 14 used twice");
   a_latch_quiet: assert property (!address_latch_high
      && !address_latch_low) else $error("latch strobe moved");
   a_oe_cause: assert property ($rose(ext_data_oe) |->
      $past(ext_rd_n, 3) == 1'b0 && $past(ext_cs_n, 3) == 1'b0)
      else $error("data driven without read strobe");
   c_read: cover property (take && !hwrite);
   c_oe: cover property ($rose(ext_data_oe));
   c_irq: cover property ($rose(irq));
   c_cs: cover property (chip_select_pin_one);
endmodule

bind ppas_port ppas_port_props u_props (.hclk(hclk), .hresetn(hresetn),
   .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
   .hreadyout(hreadyout), .hresp(hresp), .ext_cs_n(ext_cs_n),
   .ext_rd_n(ext_rd_n), .ext_data_oe(ext_data_oe),
   .port_address_lines(port_address_lines),
   .address_line_14(address_line_14),
   .chip_select_pin_one(chip_select_pin_one),
   .address_latch_high(address_latch_high),
   .address_latch_low(address_latch_low),
   .pad_port_owned(pad_port_owned), .irq(irq));

// *** sim/ppas_ext_host.sv ***
// external parallel master that drives the slave strobes
`timescale 1ns/1ps
module ppas_ext_host #(
   parameter GAP = 6
) (
   input wire hclk,
   input wire [7:0] ext_data_out,
   input wire ext_data_oe,
   output logic ext_cs_n = 1'b1,
   output logic ext_rd_n = 1'b1,
   output logic ext_wr_n = 1'b1,
   output logic [1:0] ext_addr = 2'h0,
   output logic [7:0] ext_data_in = 8'h00
);
   // strobes held GAP clocks so the three-flop sync sees both levels
   task automatic xw(input logic [1:0] a, input logic [7:0] d);
      @(posedge hclk);
      ext_cs_n <= 1'b0;
      ext_addr <= a;
      ext_data_in <= d;
      repeat (3) @(posedge hclk);
      ext_wr_n <= 1'b0;
      repeat (GAP) @(posedge hclk);
      ext_wr_n <= 1'b1;
      ext_cs_n <= 1'b1;
      ext_addr <= ~a;
      ext_data_in <= ~d;
      repeat (GAP) @(posedge hclk);
   endtask
   // no drive seen within the bound returns unknown data
   task automatic xr(input logic [1:0] a, output logic [7:0] d);
      int i;
      @(posedge hclk);
      ext_cs_n <= 1'b0;
      ext_addr <= a;
      repeat (3) @(posedge hclk);
      ext_rd_n <= 1'b0;
      for (i = 0; i < 12 && ext_data_oe !== 1'b1; i++)
         @(posedge hclk);
      @(posedge hclk);
      d = (ext_data_oe === 1'b1) ? ext_data_out : 8'hxx;
      ext_rd_n <= 1'b1;
      ext_cs_n <= 1'b1;
      ext_addr <= ~a;
      repeat (GAP) @(posedge hclk);
   endtask
endmodule

// *** sim/testbench.sv ***
// self-checking bench for the parallel port block
`timescale 1ns/1ps
`include "ppas_regs.vh"
module testbench;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] haddr = 32'h0000_0000;
   logic [31:0] hwdata = 32'h0000_0000;
   logic hreadyout, hresp, ext_cs_n, ext_rd_n, ext_wr_n, ext_data_oe, irq;
   logic address_line_14, chip_select_pin_one;
   logic address_latch_high, address_latch_low;
   logic [31:0] hrdata;
   logic [1:0] ext_addr;
   logic [7:0] ext_data_in, ext_data_out, b;
   logic [10:0] port_address_lines;
   logic [14:0] pad_port_owned;
   int n_errors = 0;
   int checked = 0;
   int k;
   always #50 hclk = ~hclk;
   ppas_port u_ppas_port (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .ext_cs_n(ext_cs_n),
      .ext_rd_n(ext_rd_n), .ext_wr_n(ext_wr_n), .ext_addr(ext_addr),
      .ext_data_in(ext_data_in), .ext_data_out(ext_data_out),
      .ext_data_oe(ext_data_oe), .port_address_lines(port_address_lines),
      .address_line_14(address_line_14),
      .chip_select_pin_one(chip_select_pin_one),
      .address_latch_high(address_latch_high),
      .address_latch_low(address_latch_low),
      .pad_port_owned(pad_port_owned), .irq(irq));
   ppas_ext_host u_ppas_ext_host (.hclk(hclk), .ext_data_out(ext_data_out),
      .ext_data_oe(ext_data_oe), .ext_cs_n(ext_cs_n), .ext_rd_n(ext_rd_n),
      .ext_wr_n(ext_wr_n), .ext_addr(ext_addr), .ext_data_in(ext_data_in));
   task end_sim;
      $display("checks %0d, mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e) begin
         n_errors++;
         $display("unexpected %0t: got %h want %h", $time, g, e);
      end
   endtask
   // waits for hready high at a rising edge, bounded
   task automatic wt;
      int i;
      for (i = 0; i < 50; i++) begin
         @(posedge hclk);
         if (hreadyout === 1'b1) break;
      end
      if (i >= 50) begin
         n_errors++;
         $display("unexpected %0t: bus hang", $time);
         end_sim;
      end
   endtask
   task bw(input logic [31:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= 1'b1;
      htrans <= 2'h2;
      wt;
      htrans <= 2'h0;
      hwdata <= d;
      wt;
   endtask
   task rr(input logic [31:0] a, input logic [31:0] e);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= 1'b0;
      htrans <= 2'h2;
      wt;
      htrans <= 2'h0;
      wt;
      chk(hrdata, e);
   endtask
   // pad ownership, address lines, then line 14 as address and select
   task pins(input logic [14:0] p, input logic [10:0] l, input logic [1:0] c);
      repeat (2) @(posedge hclk);
      chk({17'h0, pad_port_owned}, {17'h0, p});
      chk({21'h0, port_address_lines}, {21'h0, l});
      chk({30'h0, address_line_14, chip_select_pin_one}, {30'h0, c});
   endtask
   task iq(input logic e);
      repeat (2) @(posedge hclk);
      chk({31'h0, irq}, {31'h0, e});
   endtask
   initial begin
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rr(`PPAS_OFS_STAT, 32'h0000_008F);
      rr(`PPAS_OFS_ADDR, 32'h0000_0000);
      rr(`PPAS_OFS_PINEN, 32'h0000_0000);
      bw(`PPAS_OFS_ADDR, 32'hFFFF_FFFF);
      rr(`PPAS_OFS_ADDR, 32'h0000_47FF);
      bw(`PPAS_OFS_PINEN, 32'hFFFF_FFFF);
      rr(`PPAS_OFS_PINEN, 32'h0000_47FF);
      pins(15'h47FF, 11'h7FF, 2'h2);
      bw(`PPAS_OFS_CTRL, 32'h0000_0080);
      pins(15'h47FF, 11'h7FF, 2'h1);
      bw(`PPAS_OFS_ADDR, 32'h0000_0000);
      pins(15'h47FF, 11'h000, 2'h0);
      bw(`PPAS_OFS_ADDR, 32'h0000_47FF);
      bw(`PPAS_OFS_PINEN, 32'h0000_0404);
      pins(15'h0404, 11'h404, 2'h0);
      bw(`PPAS_OFS_PINEN, 32'h0000_4003);
      bw(`PPAS_OFS_CTRL, 32'h0000_0098);
      pins(15'h4003, 11'h000, 2'h1);
      rr(32'h0000_0040, 32'h0000_0000);
      $display("test pins done");
      // enhanced slave, interrupt on buffer 3
      bw(`PPAS_OFS_IRQMASK, 32'h0000_0001);
      bw(`PPAS_OFS_CTRL, 32'h0000_4100);
      u_ppas_ext_host.xw(2'h0, 8'hA5);
      rr(`PPAS_OFS_STAT, 32'h0000_018F);
      for (k = 1; k < 4; k++)
         u_ppas_ext_host.xw(k[1:0], 8'hB0);
      rr(`PPAS_OFS_STAT, 32'h0000_8F8F);
      u_ppas_ext_host.xw(2'h0, 8'h5A);
      rr(`PPAS_OFS_STAT, 32'h0000_CF8F);
      iq(1'b1);
      bw(`PPAS_OFS_IRQMASK, 32'h0000_0000);
      iq(1'b0);
      bw(`PPAS_OFS_IRQMASK, 32'h0000_0001);
      iq(1'b1);
      rr(`PPAS_OFS_INBUF0, 32'h0000_00A5);
      rr(`PPAS_OFS_STAT, 32'h0000_4E8F);
      rr(`PPAS_OFS_IRQSTAT, 32'h0000_0009);
      iq(1'b0);
      bw(`PPAS_OFS_STAT, 32'h0000_0000);
      rr(`PPAS_OFS_STAT, 32'h0000_0E8F);
      $display("test input done");
      bw(`PPAS_OFS_OUTBUF0, 32'h0000_003C);
      rr(`PPAS_OFS_STAT, 32'h0000_0E0E);
      u_ppas_ext_host.xr(2'h0, b);
      chk({24'h0, b}, 32'h0000_003C);
      rr(`PPAS_OFS_STAT, 32'h0000_0E8F);
      u_ppas_ext_host.xr(2'h0, b);
      chk({24'h0, b}, 32'h0000_0000);
      rr(`PPAS_OFS_STAT, 32'h0000_0ECF);
      rr(`PPAS_OFS_IRQSTAT, 32'h0000_0002);
      // master mode ignores the slave strobes
      bw(`PPAS_OFS_CTRL, 32'h0000_0200);
      u_ppas_ext_host.xw(2'h1, 8'h11);
      rr(`PPAS_OFS_STAT, 32'h0000_0ECF);
      $display("test output done");
      // legacy slave, auto-increment pointers, interrupt every cycle
      bw(`PPAS_OFS_CTRL, 32'h0000_3800);
      bw(32'h0000_0024, 32'h0000_0077);
      u_ppas_ext_host.xw(2'h0, 8'hC1);
      rr(`PPAS_OFS_STAT, 32'h0000_8F4D);
      rr(`PPAS_OFS_INBUF0, 32'h0000_00C1);
      u_ppas_ext_host.xw(2'h0, 8'hC2);
      rr(`PPAS_OFS_STAT, 32'h0000_4E4D);
      u_ppas_ext_host.xr(2'h0, b);
      chk({24'h0, b}, 32'h0000_0000);
      u_ppas_ext_host.xr(2'h0, b);
      chk({24'h0, b}, 32'h0000_0077);
      iq(1'b1);
      rr(`PPAS_OFS_IRQSTAT, 32'h0000_0007);
      $display("test legacy done");
      end_sim;
   end
endmodule
